// File: verilog/led_channel_config_regs.sv
// Overview of operation
// - read-only low fault register at 0x04, reset zero, commands 0x09/0x0a
// - fault bit n belongs to channel n; one means fault seen
// - only diagnostic logic sets fault bits; bus writes ignored
// - fault latches only inside diagnostic range after 10 us unbroken
// - reading fault register returns bits then clears them
// - twelve duty registers 0x05..0x10, channel order, reset 0x00
// - duty bit 7 enables channel; zero forces output off unless standalone
// - duty bits 6:0 hold seven-bit gain written by bus
// - each duty write applies at once; host handles cycle skew
// - duty registers read and written through commands 0x01/0x02
// - version register by command 0x28: type bits 7:3, revision 2:0
// - 0x20 holds set b upper nibble high, set a upper low
// - 0x21 holds set a for channels 7..0, reset 0x00
// - standalone: select pin high picks set b, low set a
// - standalone bit zero turns channel on, one turns off
// - standalone registers accessed through commands 0x20/0x21/0x28
// - diagnostic range set on power-good rise, cleared on fall
`timescale 1ns/1ps
`default_nettype none
module led_channel_config_regs #(
	parameter logic [4:0] PART_TYPE_CODE = 5'h15, // arbitrary value
	parameter logic [2:0] REVISION_CODE = 3'h2 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire led_cfg_pkg::reg_req_t reg_req,
	output led_cfg_pkg::reg_rsp_t reg_rsp,
	input wire logic [led_cfg_pkg::NUM_LOW_CH-1:0] fault_detect,
	input wire logic power_good_rise,
	input wire logic power_good_fall,
	input wire logic standalone_operation,
	input wire logic set_select_pin,
	output logic diag_range,
	output logic [led_cfg_pkg::NUM_LOW_CH-1:0] channel_fault_flags,
	output logic [led_cfg_pkg::NUM_CH-1:0] channel_on,
	output logic [led_cfg_pkg::NUM_CH*led_cfg_pkg::DUTY_GAIN_W-1:0] channel_gain
);
	import led_cfg_pkg::*;

	logic diag_range_r;
	logic [NUM_LOW_CH-1:0] fault_r;
	logic [FCNT_W-1:0] fcnt_r [NUM_LOW_CH];
	logic [7:0] duty_r [NUM_CH];
	logic [7:0] sa_upper_r;
	logic [7:0] sa_a_low_r;
	logic [7:0] sa_b_low_r;
	logic [NUM_CH-1:0] set_a;
	logic [NUM_CH-1:0] set_b;
	logic [NUM_CH-1:0] on_nxt;
	logic [NUM_CH*DUTY_GAIN_W-1:0] gain_nxt;
	logic [7:0] rd_nxt;
	logic fault_rd;
	logic sa_cmd;
	logic duty_cmd;
	logic fault_cmd;

	// fault path
	logic diag_range_nxt;
	logic [NUM_LOW_CH-1:0] fault_nxt;
	logic [NUM_LOW_CH-1:0] fault_live;
	logic [NUM_LOW_CH-1:0] fault_full;
	logic [NUM_LOW_CH-1:0] fault_hit;

	// write decode
	logic duty_wr;
	logic [NUM_CH-1:0] duty_sel;
	logic sa_wr;
	logic sa_upper_wr;
	logic sa_a_low_wr;
	logic sa_b_low_wr;

	// channel and read paths
	logic [NUM_CH-1:0] sa_off;
	logic [NUM_CH-1:0] bus_on;
	logic [7:0] version_val;
	logic [7:0] fault_rd_val;
	logic [7:0] duty_rd_val;
	logic [7:0] sa_rd_val;

	// true when the address falls in the duty window
	function automatic logic is_duty(input logic [7:0] a);
		return (a >= ADDR_DUTY_FIRST) && (a <= ADDR_DUTY_LAST);
	endfunction : is_duty

	// channel index of a duty address
	function automatic logic [3:0] duty_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - ADDR_DUTY_FIRST;
		return d[3:0];
	endfunction : duty_idx

	// true once a persistence counter has run its full length
	function automatic logic count_full(input logic [FCNT_W-1:0] c);
		return c == FCNT_W'(FAULT_CYCLES);
	endfunction : count_full

	// true on the last cycle before a persistence counter fills
	function automatic logic count_last(input logic [FCNT_W-1:0] c);
		return c == FCNT_W'(FAULT_CYCLES - 1);
	endfunction : count_last

	// command groups
	assign duty_cmd = (reg_req.cmd == CMD_DUTY_WR) || (reg_req.cmd == CMD_DUTY_RD);
	assign fault_cmd = (reg_req.cmd == CMD_FAULT_A) || (reg_req.cmd == CMD_FAULT_B);
	assign sa_cmd = (reg_req.cmd == CMD_SA_A) || (reg_req.cmd == CMD_SA_B)
		|| (reg_req.cmd == CMD_SA_C);
	assign fault_rd = reg_req.rd && fault_cmd && (reg_req.addr == ADDR_FAULT_LOW);

	// write strobes per register group; writes elsewhere fall away
	assign duty_wr = reg_req.wr && duty_cmd && is_duty(reg_req.addr);
	assign sa_wr = reg_req.wr && sa_cmd;
	assign sa_upper_wr = sa_wr && (reg_req.addr == ADDR_SA_UPPER);
	assign sa_a_low_wr = sa_wr && (reg_req.addr == ADDR_SA_A_LOW);
	assign sa_b_low_wr = sa_wr && (reg_req.addr == ADDR_SA_B_LOW);

	// one-hot write select across the duty registers
	always_comb begin
		duty_sel = '0;
		if (duty_wr) begin
			duty_sel[duty_idx(reg_req.addr)] = 1'b1;
		end
	end

	// per-channel fault qualification: live fault, full run, set event
	always_comb begin
		fault_live = '0;
		fault_full = '0;
		fault_hit = '0;
		for (int i = 0; i < NUM_LOW_CH; i++) begin
			fault_live[i] = fault_detect[i] && diag_range_r;
			fault_full[i] = count_full(fcnt_r[i]);
			fault_hit[i] = fault_live[i] && count_last(fcnt_r[i]);
		end
	end

	// range flag next value; a rise wins over a fall in one cycle
	always_comb begin
		diag_range_nxt = diag_range_r;
		if (power_good_fall) begin
			diag_range_nxt = 1'b0;
		end
		if (power_good_rise) begin
			diag_range_nxt = 1'b1;
		end
	end

	// diagnostic range flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			diag_range_r <= 1'b0;
		end else begin
			diag_range_r <= diag_range_nxt;
		end
	end

	// per-channel persistence counters
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_LOW_CH; i++) begin
				fcnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_LOW_CH; i++) begin
				if (!fault_live[i]) begin
					fcnt_r[i] <= '0;
				end else if (!fault_full[i]) begin
					fcnt_r[i] <= fcnt_r[i] + FCNT_W'(1);
				end
			end
		end
	end

	// next fault flags: read clears, a set in the same cycle wins
	always_comb begin
		fault_nxt = fault_r;
		if (fault_rd) begin
			fault_nxt = '0;
		end
		fault_nxt = fault_nxt | fault_hit;
	end

	// fault flags, set by the diagnostic path only, cleared by a fault register read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_r <= RST_FAULT;
		end else begin
			fault_r <= fault_nxt;
		end
	end

	// duty registers, written as each access arrives
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_r[i] <= RST_DUTY;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (duty_sel[i]) begin
					duty_r[i] <= reg_req.wdata;
				end
			end
		end
	end

	// standalone upper nibbles of both sets
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sa_upper_r <= RST_SA;
		end else if (sa_upper_wr) begin
			sa_upper_r <= reg_req.wdata;
		end
	end

	// standalone set a, channels 7..0
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sa_a_low_r <= RST_SA;
		end else if (sa_a_low_wr) begin
			sa_a_low_r <= reg_req.wdata;
		end
	end

	// standalone set b, channels 7..0
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sa_b_low_r <= RST_SA;
		end else if (sa_b_low_wr) begin
			sa_b_low_r <= reg_req.wdata;
		end
	end

	// assemble both standalone sets
	assign set_a = {sa_upper_r[SA_B_UPPER_LSB-1:0], sa_a_low_r};
	assign set_b = {sa_upper_r[7:SA_B_UPPER_LSB], sa_b_low_r};

	// off bits of whichever standalone set the pin picks
	assign sa_off = set_select_pin ? set_b : set_a;

	// bus mode: duty enable bit per channel
	always_comb begin
		bus_on = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			bus_on[i] = duty_r[i][DUTY_EN_BIT];
		end
	end

	// channel on; in standalone a zero bit means on
	always_comb begin
		on_nxt = bus_on;
		if (standalone_operation) begin
			on_nxt = ~sa_off;
		end
	end

	// gain fields packed channel by channel
	always_comb begin
		gain_nxt = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			gain_nxt[i*DUTY_GAIN_W +: DUTY_GAIN_W] = duty_r[i][DUTY_GAIN_W-1:0];
		end
	end

	// fixed version code
	assign version_val = {PART_TYPE_CODE, REVISION_CODE};

	// fault group read value
	assign fault_rd_val = (reg_req.addr == ADDR_FAULT_LOW) ? fault_r : 8'h00;

	// duty group read value
	always_comb begin
		duty_rd_val = 8'h00;
		if (is_duty(reg_req.addr)) begin
			duty_rd_val = duty_r[duty_idx(reg_req.addr)];
		end
	end

	// standalone group read value; version shares the group
	always_comb begin
		case (reg_req.addr)
			ADDR_SA_UPPER: sa_rd_val = sa_upper_r;
			ADDR_SA_A_LOW: sa_rd_val = sa_a_low_r;
			ADDR_SA_B_LOW: sa_rd_val = sa_b_low_r;
			ADDR_VERSION: sa_rd_val = version_val;
			default: sa_rd_val = 8'h00;
		endcase
	end

	// read data mux by command group; anything else reads zero
	always_comb begin
		rd_nxt = 8'h00;
		if (fault_cmd) begin
			rd_nxt = fault_rd_val;
		end else if (duty_cmd) begin
			rd_nxt = duty_rd_val;
		end else if (sa_cmd) begin
			rd_nxt = sa_rd_val;
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rsp <= '0;
		end else begin
			reg_rsp.valid <= reg_req.rd;
			reg_rsp.data <= reg_req.rd ? rd_nxt : 8'h00;
		end
	end

	// registered range output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			diag_range <= 1'b0;
		end else begin
			diag_range <= diag_range_r;
		end
	end

	// registered copy of the fault flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			channel_fault_flags <= '0;
		end else begin
			channel_fault_flags <= fault_r;
		end
	end

	// registered channel on bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			channel_on <= '0;
		end else begin
			channel_on <= on_nxt;
		end
	end

	// registered channel gains
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			channel_gain <= '0;
		end else begin
			channel_gain <= gain_nxt;
		end
	end
endmodule : led_channel_config_regs
`default_nettype wire

// File: verilog/led_cfg_pkg.sv
`default_nettype none
package led_cfg_pkg;
	// channel counts
	localparam int NUM_CH = 12;
	localparam int NUM_LOW_CH = 8;
	// register addresses
	localparam logic [7:0] ADDR_FAULT_LOW = 8'h04;
	localparam logic [7:0] ADDR_DUTY_FIRST = 8'h05;
	localparam logic [7:0] ADDR_DUTY_LAST = 8'h10;
	localparam logic [7:0] ADDR_SA_UPPER = 8'h20;
	localparam logic [7:0] ADDR_SA_A_LOW = 8'h21;
	localparam logic [7:0] ADDR_SA_B_LOW = 8'h22;
	localparam logic [7:0] ADDR_VERSION = 8'h28;
	// bus command codes
	localparam logic [7:0] CMD_DUTY_WR = 8'h01;
	localparam logic [7:0] CMD_DUTY_RD = 8'h02;
	localparam logic [7:0] CMD_FAULT_A = 8'h09;
	localparam logic [7:0] CMD_FAULT_B = 8'h0a;
	localparam logic [7:0] CMD_SA_A = 8'h20;
	localparam logic [7:0] CMD_SA_B = 8'h21;
	localparam logic [7:0] CMD_SA_C = 8'h28;
	// field positions
	localparam int DUTY_EN_BIT = 7;
	localparam int DUTY_GAIN_W = 7;
	localparam int VER_TYPE_LSB = 3;
	localparam int SA_B_UPPER_LSB = 4;
	// reset values
	localparam logic [7:0] RST_FAULT = 8'h00;
	localparam logic [7:0] RST_DUTY = 8'h00;
	localparam logic [7:0] RST_SA = 8'h00;
	// fault debounce time
	localparam int CLK_MHZ = 200;
	localparam int FAULT_TIME_US = 10;
	localparam int FAULT_CYCLES = FAULT_TIME_US * CLK_MHZ;
	localparam int FCNT_W = $clog2(FAULT_CYCLES + 1);

	// one register access, presented by the serial protocol engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] cmd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// read answer
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} reg_rsp_t;
endpackage : led_cfg_pkg
`default_nettype wire

// File: verif/led_cfg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module led_cfg_properties #(
	parameter logic [4:0] PART_TYPE_CODE = 5'h15, // arbitrary value
	parameter logic [2:0] REVISION_CODE = 3'h2 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire led_cfg_pkg::reg_req_t reg_req,
	input wire led_cfg_pkg::reg_rsp_t reg_rsp,
	input wire logic [7:0] fault_detect,
	input wire logic power_good_rise,
	input wire logic power_good_fall,
	input wire logic standalone_operation,
	input wire logic set_select_pin,
	input wire logic diag_range,
	input wire logic [7:0] channel_fault_flags,
	input wire logic [11:0] channel_on,
	input wire logic [83:0] channel_gain
);
	import led_cfg_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// read of the fault register while no fault is present
	sequence fault_rd_s;
		reg_req.rd && reg_req.cmd == CMD_FAULT_A && reg_req.addr == ADDR_FAULT_LOW && fault_detect == 8'h00;
	endsequence
	// write of channel 0 duty with bus mode kept
	sequence duty0_wr_s;
		reg_req.wr && reg_req.cmd == CMD_DUTY_WR && reg_req.addr == ADDR_DUTY_FIRST ##1 !standalone_operation;
	endsequence
	read_answer_a: assert property (reg_req.rd |=> reg_rsp.valid) else $error("read unanswered");
	read_clear_a: assert property (fault_rd_s |-> ##2 channel_fault_flags == 8'h00) else $error("no clear");
	flag_cause_a: assert property ((channel_fault_flags & ~$past(channel_fault_flags) & ~$past(fault_detect)) == 8'h00) else $error("flag without fault");
	flag_hold_a: assert property (!reg_req.rd |-> ##2 (channel_fault_flags & $past(channel_fault_flags)) == $past(channel_fault_flags)) else $error("flag lost");
	range_rise_a: assert property ($rose(diag_range) |-> $past(power_good_rise, 2)) else $error("range rose alone");
	range_fall_a: assert property ($fell(diag_range) |-> $past(power_good_fall, 2)) else $error("range fell alone");
	duty_apply_a: assert property (duty0_wr_s |=> channel_on[0] == $past(reg_req.wdata[7], 2) && channel_gain[6:0] == $past(reg_req.wdata[6:0], 2)) else $error("duty not applied");
	version_read_a: assert property (reg_req.rd && reg_req.cmd == CMD_SA_C && reg_req.addr == ADDR_VERSION |=> reg_rsp.data == {PART_TYPE_CODE, REVISION_CODE}) else $error("bad version");
endmodule : led_cfg_properties
`default_nettype wire

// File: verif/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input wire logic clk,
	output var led_cfg_pkg::reg_req_t reg_req,
	input wire led_cfg_pkg::reg_rsp_t reg_rsp
);
	import led_cfg_pkg::*;
	initial reg_req = '0;
	// one byte per access, held over one rising edge; answer taken while it stands
	task automatic xfer(input logic w, input logic [7:0] c, a, d, output logic v,
		output logic [7:0] q);
		@(negedge clk);
		reg_req = '{wr: w, rd: !w, cmd: c, addr: a, wdata: d};
		@(negedge clk);
		v = reg_rsp.valid;
		q = reg_rsp.data;
		reg_req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, addr: ~a, wdata: ~d};
	endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import led_cfg_pkg::*;
	logic clk, rst = 1, pg_rise = 0, pg_fall = 0, sa = 0, sel = 0, diag_range, v;
	logic [7:0] fault_detect = '0, q, flags;
	logic [11:0] ch_on;
	logic [83:0] gain;
	reg_req_t req;
	reg_rsp_t rsp;
	int err_total = 0, check_count = 0;
	// 200 MHz clock
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	host_bus_model hst (.clk, .reg_req(req), .reg_rsp(rsp));
	led_channel_config_regs DUT (.clk, .rst, .reg_req(req), .reg_rsp(rsp), .fault_detect,
		.power_good_rise(pg_rise), .power_good_fall(pg_fall), .standalone_operation(sa),
		.set_select_pin(sel), .diag_range, .channel_fault_flags(flags), .channel_on(ch_on),
		.channel_gain(gain));
	task automatic chk(input logic [11:0] got, exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] c, a, exp);
		hst.xfer(1'b0, c, a, 8'h00, v, q);
		chk(12'(v), 12'h001);
		chk(12'(q), 12'(exp));
	endtask : rd
	task automatic wr(input logic [7:0] c, a, d);
		hst.xfer(1'b1, c, a, d, v, q);
		chk(12'(v), 12'h000);
	endtask : wr
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk) rst = 0;
		rd(CMD_DUTY_RD, ADDR_DUTY_LAST, RST_DUTY);
		rd(CMD_SA_A, ADDR_SA_UPPER, RST_SA);
		rd(CMD_SA_B, ADDR_SA_A_LOW, RST_SA);
		rd(CMD_FAULT_A, ADDR_FAULT_LOW, RST_FAULT);
		$display("reset test done");
		for (int i = 0; i < NUM_CH; i++) begin
			wr(CMD_DUTY_WR, ADDR_DUTY_FIRST + 8'(i), 8'h80 | 8'(i));
		end
		wr(CMD_FAULT_A, ADDR_DUTY_FIRST, 8'h00);
		wr(CMD_DUTY_WR, ADDR_DUTY_LAST, 8'h0b);
		for (int i = 0; i < NUM_CH; i++) begin
			rd(CMD_DUTY_RD, ADDR_DUTY_FIRST + 8'(i), 8'(i) | (i < 11 ? 8'h80 : 8'h00));
			chk(12'(gain[7*i +: 7]), 12'(i));
		end
		chk(ch_on, 12'h7ff);
		wr(CMD_SA_C, ADDR_VERSION, 8'h00);
		rd(CMD_SA_C, ADDR_VERSION, 8'haa);
		rd(CMD_SA_A, 8'h30, 8'h00);
		$display("duty test done");
		@(negedge clk) sa = 1;
		wr(CMD_SA_B, ADDR_SA_A_LOW, 8'h0f);
		wr(CMD_SA_A, ADDR_SA_UPPER, 8'h5a);
		rd(CMD_SA_C, ADDR_SA_UPPER, 8'h5a);
		chk(ch_on, 12'h5f0);
		@(negedge clk) sel = 1;
		repeat (2) @(negedge clk);
		chk(ch_on, 12'haff);
		sa = 0;
		$display("standalone test done");
		pg_rise = 1;
		@(negedge clk) pg_rise = 0;
		fault_detect = 8'h05;
		repeat (1000) @(negedge clk);
		chk(12'(diag_range), 12'h001);
		fault_detect = 8'h07;
		repeat (990) @(negedge clk);
		chk(12'(flags), 12'h000);
		for (int n = 0; n < 20 && flags === 8'h00; n++) @(negedge clk);
		chk(12'(flags), 12'h005);
		if (flags !== 8'h05) tally_and_finish();
		fault_detect = 8'h00;
		wr(CMD_FAULT_A, ADDR_FAULT_LOW, 8'hff);
		rd(CMD_FAULT_B, ADDR_FAULT_LOW, 8'h05);
		rd(CMD_FAULT_A, ADDR_FAULT_LOW, 8'h00);
		pg_fall = 1;
		@(negedge clk) pg_fall = 0;
		repeat (2) @(negedge clk);
		chk(12'(diag_range), 12'h000);
		$display("fault test done");
		tally_and_finish();
	end
endmodule : tb
bind led_channel_config_regs led_cfg_properties #(.PART_TYPE_CODE(PART_TYPE_CODE),
	.REVISION_CODE(REVISION_CODE)) props (.clk, .rst, .reg_req, .reg_rsp, .fault_detect,
	.power_good_rise, .power_good_fall, .standalone_operation, .set_select_pin, .diag_range,
	.channel_fault_flags, .channel_on, .channel_gain);
`default_nettype wire
